/* pkg/asrc_map.vh */
// timing constants and field widths for the asynchronous sram byte-lane controller
`ifndef ASRC_MAP_VH
`define ASRC_MAP_VH
// clock period in picoseconds (40 mhz)
`define ASRC_CLK_PS 25000
// times in nanoseconds, as printed
`define ASRC_OE_ACCESS_MAX_NS 10
`define ASRC_OE_FLOAT_MAX_NS 10
`define ASRC_SELECT_ACCESS_MAX_NS 25
`define ASRC_SELECT_FLOAT_MAX_NS 10
`define ASRC_WRITE_FLOAT_MAX_NS 10
`define ASRC_WRITE_REDRIVE_MIN_NS 5
`define ASRC_STROBE_TO_DESELECT_MIN_NS 20
`define ASRC_SELECT_TO_STROBE_END_MIN_NS 20
`define ASRC_SELECT_PULSE_MIN_NS 20
`define ASRC_ADDR_TO_WRITE_END_MIN_NS 20
`define ASRC_CYCLE_TIME_MIN_NS 25
`define ASRC_DESELECT_TO_RETENTION_NS 0
// least times round up, at least one cycle
`define ASRC_CYC_UP(ns) ((((ns) * 1000 + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS) < 1 ? 1 : \
  (((ns) * 1000 + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS))
`define ASRC_ADDR_W 19
`define ASRC_DATA_W 8
`define ASRC_CNT_W 4
`endif

/* rtl/asrc_timer.v */
// down-counter that marks the end of a phase with a one-cycle done pulse
`timescale 1ns/1ps
module asrc_timer #(
  parameter W = 4
) (
  input wire clk_in,
  input wire resetn_in,
  input wire load_in,
  input wire [W-1:0] count_in,
  output wire done_out,
  output wire busy_out
);
  reg [W-1:0] cnt_r;
  reg [W-1:0] cnt_nxt;
  always @*
  begin
    cnt_nxt = cnt_r;
    if (load_in)
      cnt_nxt = count_in;
    else if (cnt_r != {W{1'b0}})
      cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
  end
  always @(posedge clk_in)
  begin
    if (!resetn_in)
      cnt_r <= {W{1'b0}};
    else
      cnt_r <= cnt_nxt;
  end
  assign busy_out = (cnt_r != {W{1'b0}});
  // done follows the count alone, so a sequencer that reloads on done forms no loop
  assign done_out = (cnt_r == {{(W-1){1'b0}}, 1'b1});
endmodule

/* rtl/asrc_ctrl.v */
// bus master for one byte lane of an asynchronous static memory
// Behaviour
// - after write strobe falls, wait at least 10 ns before driving write data.
// - release data pins as the write strobe rises, well within 5 ns.
// - write strobe held low at least 20 ns before select rises.
// - select held low at least 20 ns before the write strobe rises.
// - select pulse of a write lasts at least 20 ns.
// - address stable at least 20 ns before the write ends.
// - select stays high throughout retention; no delay needed before it.
// - read address changes no faster than the 25 ns cycle time.
`timescale 1ns/1ps
`include "asrc_map.vh"
module asrc_ctrl #(
  parameter AW = `ASRC_ADDR_W,
  parameter DW = `ASRC_DATA_W
) (
  input wire clk_in,
  input wire resetn_in,
  // user side
  input wire req_valid_in,
  input wire req_write_in,
  input wire [AW-1:0] req_addr_in,
  input wire [DW-1:0] req_wdata_in,
  output wire req_ready_out,
  output reg rsp_valid_out,
  output reg [DW-1:0] rsp_rdata_out,
  input wire retain_in,
  output wire retain_ok_out,
  // memory pins
  output reg select_n_out,
  output reg write_strobe_n_out,
  output reg out_drive_n_out,
  output reg [AW-1:0] addr_out,
  output reg [DW-1:0] dq_out,
  output reg dq_oe_n_out,
  input wire [DW-1:0] dq_in
);
  // ****************************************
  // cycle counts
  // ****************************************
  // rounding is done wide, then cut to the timer width on purpose
  localparam integer N_READ = `ASRC_CYC_UP(`ASRC_SELECT_ACCESS_MAX_NS);
  localparam integer N_FLOAT = `ASRC_CYC_UP(`ASRC_SELECT_FLOAT_MAX_NS);
  localparam integer N_WFLT = `ASRC_CYC_UP(`ASRC_WRITE_FLOAT_MAX_NS);
  localparam integer N_WPULSE = `ASRC_CYC_UP(`ASRC_STROBE_TO_DESELECT_MIN_NS);
  localparam integer N_CYCLE = `ASRC_CYC_UP(`ASRC_CYCLE_TIME_MIN_NS);
  localparam [3:0] C_READ = N_READ[3:0];
  localparam [3:0] C_FLOAT = N_FLOAT[3:0];
  localparam [3:0] C_WFLT = N_WFLT[3:0];
  localparam [3:0] C_WPULSE = N_WPULSE[3:0];
  localparam [3:0] C_CYCLE = N_CYCLE[3:0];

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_READ = 3'd1;
  localparam [2:0] S_WFLT = 3'd2;
  localparam [2:0] S_WDRV = 3'd3;
  localparam [2:0] S_REC = 3'd4;
  localparam [2:0] S_RET = 3'd5;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg load;
  reg [3:0] load_cnt;
  wire t_done;

  // ****************************************
  // helpers
  // ****************************************
  // cycles left of a budget after a phase already spent; never zero,
  // since a load of zero would leave the timer idle and the sequencer stuck
  function [3:0] gap_cycles;
    input [3:0] total;
    input [3:0] spent;
    begin
      gap_cycles = (total > spent) ? total - spent : 4'h1;
    end
  endfunction

  asrc_timer #(.W(`ASRC_CNT_W)) u_timer (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .load_in(load),
    .count_in(load_cnt),
    .done_out(t_done),
    .busy_out()
  );

  // a pending retention request wins over a new access, so select never dips
  assign req_ready_out = (state_r == S_IDLE) && !retain_in;
  assign retain_ok_out = (state_r == S_RET);

  wire take = req_valid_in && req_ready_out;

  // ****************************************
  // sequencer
  // ****************************************
  always @*
  begin
    state_nxt = state_r;
    load = 1'b0;
    load_cnt = 4'h0;
    case (state_r)
      S_IDLE:
      begin
        if (retain_in)
          state_nxt = S_RET;
        else if (take && req_write_in)
        begin
          state_nxt = S_WFLT;
          load = 1'b1;
          load_cnt = C_WFLT;
        end
        else if (take)
        begin
          state_nxt = S_READ;
          load = 1'b1;
          load_cnt = C_READ;
        end
      end
      S_READ:
        if (t_done)
        begin
          state_nxt = S_REC;
          load = 1'b1;
          load_cnt = C_FLOAT;
        end
      S_WFLT:
        if (t_done)
        begin
          state_nxt = S_WDRV;
          load = 1'b1;
          load_cnt = gap_cycles(C_WPULSE, C_WFLT);
        end
      S_WDRV:
        if (t_done)
        begin
          state_nxt = S_REC;
          load = 1'b1;
          load_cnt = gap_cycles(C_CYCLE, C_WPULSE);
        end
      S_REC:
        if (t_done)
          state_nxt = S_IDLE;
      S_RET:
        if (!retain_in)
        begin
          state_nxt = S_REC;
          load = 1'b1;
          load_cnt = C_CYCLE; // recovery time equals one cycle time
        end
      default:
        state_nxt = S_IDLE;
    endcase
  end

  // ****************************************
  // registered pins
  // ****************************************
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state_r <= S_IDLE;
      select_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      out_drive_n_out <= 1'b1;
      addr_out <= {AW{1'b0}};
      dq_out <= {DW{1'b0}};
      dq_oe_n_out <= 1'b1;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= {DW{1'b0}};
    end
    else
    begin
      state_r <= state_nxt;
      rsp_valid_out <= 1'b0;
      case (state_nxt)
        S_READ:
        begin
          select_n_out <= 1'b0;
          out_drive_n_out <= 1'b0;
          write_strobe_n_out <= 1'b1;
        end
        S_WFLT:
        begin
          select_n_out <= 1'b0;
          write_strobe_n_out <= 1'b0;
          out_drive_n_out <= 1'b1;
        end
        S_WDRV:
        begin
          dq_oe_n_out <= 1'b0;
        end
        default:
        begin
          select_n_out <= 1'b1;
          write_strobe_n_out <= 1'b1;
          out_drive_n_out <= 1'b1;
          dq_oe_n_out <= 1'b1;
        end
      endcase
      // address and data held for the whole access
      if (take)
      begin
        addr_out <= req_addr_in;
        dq_out <= req_wdata_in;
      end
      // sample at the end of the access window
      // the closing edge gives the memory the whole select time to answer
      if (state_r == S_READ && t_done)
      begin
        rsp_rdata_out <= dq_in;
        rsp_valid_out <= 1'b1;
      end
    end
  end
endmodule

/* testbench/asrc_sram_model.sv */
// behavioural memory lane on the far side of the controller
`timescale 1ns/1ps
module asrc_sram_model #(parameter DLY = 8) (
  input wire select_n_in,
  input wire write_strobe_n_in,
  input wire out_drive_n_in,
  input wire [18:0] addr_in,
  input wire [7:0] dq_in,
  input wire dq_oe_n_in,
  output wire [7:0] dq_out
);
  reg [7:0] mem [0:524287];
  reg [7:0] last_r = 8'h00;
  reg [7:0] wd_r = 8'h00;
  reg [18:0] wa_r = 19'h00000;
  reg wip_r = 1'b0;
  wire rd = !select_n_in && !out_drive_n_in && write_strobe_n_in;
  // released pins show the inverse of the last value, never a stale match
  assign #(DLY) dq_out = rd ? mem[addr_in] : ~last_r;
  always @(select_n_in or write_strobe_n_in or out_drive_n_in or addr_in or dq_in or dq_oe_n_in)
  begin
    if (rd)
      last_r = mem[addr_in];
    if (!select_n_in && !write_strobe_n_in)
    begin
      wip_r = 1'b1;
      wa_r = addr_in;
      if (!dq_oe_n_in)
        wd_r = dq_in;
    end
    else if (wip_r)
    begin
      mem[wa_r] = wd_r;
      wip_r = 1'b0;
    end
  end
endmodule

/* testbench/asrc_ctrl_sva.sv */
// pin timing assertions for the sram controller
`timescale 1ns/1ps
module asrc_ctrl_sva (
  input wire clk_in,
  input wire resetn_in,
  input wire retain_in,
  input wire req_ready_out,
  input wire retain_ok_out,
  input wire rsp_valid_out,
  input wire select_n_out,
  input wire write_strobe_n_out,
  input wire out_drive_n_out,
  input wire [18:0] addr_out,
  input wire dq_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_strobe_width: assert property ($fell(write_strobe_n_out) |-> (!write_strobe_n_out && !select_n_out)[*2])
    else $error("write pulse too short");
  a_float_wait: assert property ($fell(write_strobe_n_out) |-> dq_oe_n_out ##1 !dq_oe_n_out)
    else $error("data driven too early");
  a_release_end: assert property ($rose(write_strobe_n_out) |-> dq_oe_n_out && $past(select_n_out) == 1'b0)
    else $error("bad write end");
  a_addr_hold: assert property (!write_strobe_n_out && !$fell(write_strobe_n_out) |-> $stable(addr_out))
    else $error("address moved in write");
  a_no_clash: assert property (!dq_oe_n_out |-> out_drive_n_out && !write_strobe_n_out)
    else $error("bus contention");
  a_read_window: assert property (rsp_valid_out |-> $past(select_n_out) == 1'b0 && $past(out_drive_n_out) == 1'b0)
    else $error("read sampled outside window");
  a_retain_sel: assert property (retain_ok_out |-> select_n_out && write_strobe_n_out)
    else $error("select low in retention");
  a_retain_block: assert property (retain_ok_out && !retain_in |=> !retain_ok_out && select_n_out && !req_ready_out)
    else $error("no recovery after retention");
endmodule
bind asrc_ctrl asrc_ctrl_sva chk (.clk_in(clk_in), .resetn_in(resetn_in), .retain_in(retain_in),
  .req_ready_out(req_ready_out), .retain_ok_out(retain_ok_out), .rsp_valid_out(rsp_valid_out),
  .select_n_out(select_n_out), .write_strobe_n_out(write_strobe_n_out),
  .out_drive_n_out(out_drive_n_out), .addr_out(addr_out), .dq_oe_n_out(dq_oe_n_out));

/* testbench/tb_asrc_ctrl.sv */
// self-checking bench for the sram byte-lane controller
`timescale 1ns/1ps
`include "asrc_map.vh"
module tb_asrc_ctrl;
  reg clk_in = 1'b0;
  reg resetn_in = 1'b0;
  reg v = 1'b0, w = 1'b0, ret = 1'b0;
  reg [18:0] a = 19'h00000, ta;
  reg [7:0] d = 8'h00;
  wire rdy, rv, ok, sn, wn, on, oen;
  wire [7:0] rd, dqo, mq, bus;
  wire [18:0] ao;
  integer failures = 0, num_checks = 0, seed = 32'h742a7da2, i, k;
  reg [7:0] exp [bit [18:0]];
  reg [18:0] q [$];
  always #12.5 clk_in = ~clk_in;
  // the wire carries the controller while it drives, else the memory
  assign bus = oen ? mq : dqo;
  asrc_ctrl dut (.clk_in(clk_in), .resetn_in(resetn_in), .req_valid_in(v), .req_write_in(w),
    .req_addr_in(a), .req_wdata_in(d), .req_ready_out(rdy), .rsp_valid_out(rv),
    .rsp_rdata_out(rd), .retain_in(ret), .retain_ok_out(ok), .select_n_out(sn),
    .write_strobe_n_out(wn), .out_drive_n_out(on), .addr_out(ao), .dq_out(dqo),
    .dq_oe_n_out(oen), .dq_in(bus));
  asrc_sram_model mdl (.select_n_in(sn), .write_strobe_n_in(wn), .out_drive_n_in(on),
    .addr_in(ao), .dq_in(dqo), .dq_oe_n_in(oen), .dq_out(mq));
  task complete_run;
  begin
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  task chk(input [18:0] g, input [18:0] e);
  begin
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  // bounded wait at falling edges for a flag
  task waitf(input integer n);
  begin
    k = 0;
    while (!((n == 0) ? (rdy === 1'b1) : (n == 1) ? (rv === 1'b1) : (ok === 1'b1)) && k < 30)
    begin
      @(negedge clk_in);
      k = k + 1;
    end
    if (k == 30)
    begin
      failures = failures + 1;
      complete_run;
    end
  end
  endtask
  task xfer(input wr, input [18:0] ad, input [7:0] dt);
  begin
    @(negedge clk_in);
    v = 1'b1;
    w = wr;
    a = ad;
    d = dt;
    waitf(0);
    @(negedge clk_in);
    v = 1'b0;
    chk(ao, ad);
    if (wr)
      exp[ad] = dt;
    else
    begin
      waitf(1);
      chk(k, `ASRC_CYC_UP(`ASRC_SELECT_ACCESS_MAX_NS));
      chk(rd, exp[ad]);
      @(negedge clk_in);
      chk(rv, 1'b0);
    end
  end
  endtask
  initial
  begin
    repeat (3) @(negedge clk_in);
    resetn_in = 1'b1;
    chk({sn, wn, on, oen}, 4'hf);
    for (i = 0; i < 12; i = i + 1)
    begin
      ta = $random(seed);
      q.push_back(ta);
      xfer(1'b1, ta, $random(seed));
    end
    xfer(1'b1, q[0], ~exp[q[0]]);
    for (i = 0; i < 16; i = i + 1)
      xfer(1'b0, q[{$random(seed)} % 12], 8'h00);
    @(negedge clk_in);
    ret = 1'b1;
    waitf(2);
    repeat (4) @(negedge clk_in);
    chk({sn, rdy, ok}, 3'b101);
    ret = 1'b0;
    xfer(1'b0, q[0], 8'h00);
    xfer(1'b0, q[11], 8'h00);
    complete_run;
  end
endmodule
